// file: src/serial_port_pkg.sv
// Constants shared by the asynchronous serial port and its testbench.
//
// Contract
// - Bit rate is the baud timer overflow rate halved; overflow is clock/(256-reload).
// - A private receive timer copy is reloaded when a start edge appears.
// - Data writes go to transmit; data reads return the receive buffer only.
// - Control bit 7 picks the frame: 0 is 8-bit, 1 is 9-bit.
// - 8-bit frame: start, eight data bits LSB first, stop; ten bits.
// - In 8-bit mode an accepted byte copies its stop bit into bit 2.
// - Every data buffer write queues an outgoing character unless the transmit FIFO is full.
// - Transmit-done flag, bit 1, sets as the stop bit begins.
// - Characters are received only while receive enable, bit 4, is one.
// - 8-bit mode loads only if receive flag clear and, when filtering, stop high.
// - On overrun the first byte stays buffered; later characters are dropped.
// - 9-bit frame: start, eight data bits, programmable ninth, stop; eleven bits.
// - In 9-bit mode control bit 3 is sent as the ninth bit.
// - In 9-bit mode the ninth bit goes to bit 2; stop is ignored.
// - 9-bit mode loads only if receive flag clear and, when filtering, ninth high.
// - Receive-done flag, bit 0, sets when the stop bit is sampled and accepted.
// - Interrupt request is raised while either flag is set and enabled.
// - Hardware never clears the two flags; only a CPU write does.
// - Control bit 6 is unused, reads as one, ignores writes.

package serial_port_pkg;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  localparam logic [7:0] CTRL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR = 8'h99;

  localparam int MODE_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int FILTER_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TB8_BIT = 3;
  localparam int RB8_BIT = 2;
  localparam int TI_BIT = 1;
  localparam int RI_BIT = 0;

  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam logic [7:0] TIMER_TOP = 8'hff;
  localparam logic [7:0] TIMER_RESET = 8'h00;

  localparam logic [3:0] FRAME_LEN_8 = 4'ha;
  localparam logic [3:0] FRAME_LEN_9 = 4'hb;
  localparam logic [3:0] IDX_START = 4'h0;
  localparam logic [3:0] IDX_FIRST_DATA = 4'h1;
  localparam logic [3:0] IDX_LAST_DATA = 4'h8;
  localparam logic [3:0] IDX_NINTH = 4'h9;
  localparam logic [3:0] IDX_ONE = 4'h1;

  localparam logic [10:0] LINE_IDLE = 11'h7ff;

  typedef enum logic { RX_IDLE, RX_BUSY } rx_state_e;

endpackage

// file: src/tx_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none

module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             CLOCK,
  input  wire logic             RST,
  input  wire logic             CE,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  wire              push;
  wire              pop;

  assign in_ready  = (count_reg != FULL_COUNT);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = CE & in_valid & in_ready;
  assign pop       = CE & out_valid & out_ready;

  always_ff @(posedge CLOCK) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_SLOT) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_SLOT) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push != pop) begin
        count_reg <= push ? count_reg + 1'b1 : count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: src/serial_port.sv
// Full-duplex asynchronous serial port with 8-bit and 9-bit frames.
`timescale 1ns/100ps
`default_nettype none

module serial_port (
  input  wire logic                               CLOCK,
  input  wire logic                               RST,
  input  wire logic                               CE,
  input  wire logic [7:0]                         SFR_ADDR,
  input  wire logic                               SFR_WR,
  input  wire logic                               SFR_RD,
  input  wire logic [serial_port_pkg::DATA_W-1:0] SFR_WDATA,
  output logic      [serial_port_pkg::DATA_W-1:0] SFR_RDATA,
  input  wire logic                               TIMER_RUN,
  input  wire logic                               TIMER_TICK,
  input  wire logic [7:0]                         BAUD_RELOAD,
  input  wire logic                               SERIAL_IN,
  output logic                                    SERIAL_OUT,
  input  wire logic                               INT_ENABLE,
  output logic                                    INT_REQ,
  output logic                                    TX_READY
);

  import serial_port_pkg::*;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------

  logic        mode_reg;
  logic        filter_reg;
  logic        ren_reg;
  logic        tb8_reg;
  logic        rb8_reg;
  logic        ti_reg;
  logic        ri_reg;
  logic [7:0]  rx_buf_reg;
  logic [7:0]  rdata_reg;

  wire         wr_ctrl = CE & SFR_WR & (SFR_ADDR == CTRL_ADDR);
  wire         wr_data = CE & SFR_WR & (SFR_ADDR == DATA_ADDR);
  wire         rd_ctrl = SFR_RD & (SFR_ADDR == CTRL_ADDR);
  wire         rd_data = SFR_RD & (SFR_ADDR == DATA_ADDR);
  wire  [7:0]  ctrl_view = {mode_reg, 1'b1, filter_reg, ren_reg,
                            tb8_reg, rb8_reg, ti_reg, ri_reg};
  wire  [7:0]  rdata_next = rd_ctrl ? ctrl_view :
                            rd_data ? rx_buf_reg : UNMAPPED_READ;
  wire  [3:0]  frame_len = mode_reg ? FRAME_LEN_9 : FRAME_LEN_8;
  wire  [3:0]  last_idx = frame_len - IDX_ONE;

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------

  logic        fifo_valid;
  logic        fifo_pop_ready;
  logic [7:0]  fifo_data;

  tx_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .CLOCK     (CLOCK),
    .RST       (RST),
    .CE        (CE),
    .in_valid  (wr_data),
    .in_ready  (TX_READY),
    .in_data   (SFR_WDATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop_ready),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Baud timers
  // ----------------------------------------------------------------

  logic [7:0]  tx_cnt_reg;
  logic        tx_half_reg;
  logic [7:0]  rx_cnt_reg;
  logic        rx_half_reg;
  logic        rx_prev_reg;
  rx_state_e   rx_state_reg;

  wire         timer_step = TIMER_RUN & TIMER_TICK;
  wire         tx_ovf = timer_step & (tx_cnt_reg == TIMER_TOP);
  wire         tx_tick = tx_ovf & tx_half_reg;
  wire         start_edge = ren_reg & (rx_state_reg == RX_IDLE) &
                            rx_prev_reg & ~SERIAL_IN;
  wire         rx_ovf = timer_step & (rx_cnt_reg == TIMER_TOP) &
                        ~start_edge;
  wire         rx_sample = rx_ovf & ~rx_half_reg &
                           (rx_state_reg == RX_BUSY);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_cnt_reg  <= TIMER_RESET;
      tx_half_reg <= 1'b0;
    end else if (CE && timer_step) begin
      tx_cnt_reg  <= tx_ovf ? BAUD_RELOAD : tx_cnt_reg + 1'b1;
      tx_half_reg <= tx_half_reg ^ tx_ovf;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rx_cnt_reg  <= TIMER_RESET;
      rx_half_reg <= 1'b0;
    end else if (CE) begin
      if (start_edge) begin
        rx_cnt_reg  <= BAUD_RELOAD;
        rx_half_reg <= 1'b0;
      end else if (timer_step) begin
        rx_cnt_reg  <= rx_ovf ? BAUD_RELOAD : rx_cnt_reg + 1'b1;
        rx_half_reg <= rx_half_reg ^ rx_ovf;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------

  logic        tx_busy_reg;
  logic [10:0] tx_shift_reg;
  logic [3:0]  tx_idx_reg;
  logic        tx_ninth_reg;

  wire         tx_load = tx_tick & ~tx_busy_reg & fifo_valid;
  wire         tx_ninth = mode_reg ? tb8_reg : 1'b1;
  wire  [3:0]  tx_idx_next = tx_idx_reg + IDX_ONE;
  wire         tx_shift = tx_tick & tx_busy_reg;
  wire         ti_set = tx_shift & (tx_idx_next == last_idx);

  assign fifo_pop_ready = tx_tick & ~tx_busy_reg;
  assign SERIAL_OUT = tx_shift_reg[0];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= LINE_IDLE;
      tx_idx_reg   <= IDX_START;
      tx_ninth_reg <= 1'b1;
    end else if (CE) begin
      if (tx_load) begin
        tx_busy_reg  <= 1'b1;
        tx_shift_reg <= {1'b1, tx_ninth, fifo_data, 1'b0};
        tx_idx_reg   <= IDX_START;
        tx_ninth_reg <= tx_ninth;
      end else if (tx_shift) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_idx_reg   <= tx_idx_next;
        // A mode change during the stop bit still ends the frame cleanly.
        tx_busy_reg  <= (tx_idx_next < frame_len);
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------

  logic [3:0]  rx_idx_reg;
  logic [7:0]  rx_data_reg;
  logic        rx_ninth_reg;

  wire         rx_last = rx_sample & (rx_idx_reg == last_idx);
  wire         rx_false = rx_sample & (rx_idx_reg == IDX_START) & SERIAL_IN;
  wire         rx_bit9 = mode_reg ? rx_ninth_reg : SERIAL_IN;
  wire         rx_accept = rx_last & ~ri_reg &
                           (~filter_reg | rx_bit9);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rx_state_reg <= RX_IDLE;
      rx_prev_reg  <= 1'b1;
      rx_idx_reg   <= IDX_START;
      rx_data_reg  <= DATA_RESET;
      rx_ninth_reg <= 1'b0;
    end else if (CE) begin
      rx_prev_reg <= SERIAL_IN;
      unique case (rx_state_reg)
        RX_IDLE: begin
          if (start_edge) begin
            rx_state_reg <= RX_BUSY;
            rx_idx_reg   <= IDX_START;
          end
        end
        RX_BUSY: begin
          if (!ren_reg || rx_false || rx_last) begin
            rx_state_reg <= RX_IDLE;
          end else if (rx_sample) begin
            rx_idx_reg <= rx_idx_reg + IDX_ONE;
            if (rx_idx_reg >= IDX_FIRST_DATA &&
                rx_idx_reg <= IDX_LAST_DATA) begin
              rx_data_reg <= {SERIAL_IN, rx_data_reg[7:1]};
            end
            if (rx_idx_reg == IDX_NINTH) begin
              rx_ninth_reg <= SERIAL_IN;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register and data buffer
  // ----------------------------------------------------------------

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mode_reg   <= CTRL_RESET[MODE_BIT];
      filter_reg <= CTRL_RESET[FILTER_BIT];
      ren_reg    <= CTRL_RESET[REN_BIT];
      tb8_reg    <= CTRL_RESET[TB8_BIT];
      rb8_reg    <= CTRL_RESET[RB8_BIT];
      ti_reg     <= CTRL_RESET[TI_BIT];
      ri_reg     <= CTRL_RESET[RI_BIT];
      rx_buf_reg <= DATA_RESET;
      rdata_reg  <= UNMAPPED_READ;
    end else if (CE) begin
      if (wr_ctrl) begin
        mode_reg   <= SFR_WDATA[MODE_BIT];
        filter_reg <= SFR_WDATA[FILTER_BIT];
        ren_reg    <= SFR_WDATA[REN_BIT];
        tb8_reg    <= SFR_WDATA[TB8_BIT];
      end
      if (rx_accept) begin
        rb8_reg    <= rx_bit9;
        rx_buf_reg <= rx_data_reg;
      end else if (wr_ctrl) begin
        rb8_reg <= SFR_WDATA[RB8_BIT];
      end
      ti_reg <= ti_set | (wr_ctrl ? SFR_WDATA[TI_BIT] : ti_reg);
      ri_reg <= rx_accept | (wr_ctrl ? SFR_WDATA[RI_BIT] : ri_reg);
      if (SFR_RD) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign SFR_RDATA = rdata_reg;
  assign INT_REQ = (ti_reg | ri_reg) & INT_ENABLE;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence ctrl_read;
    CE && rd_ctrl;
  endsequence

  sequence ninth_slot;
    CE && tx_shift && mode_reg && tx_idx_reg == IDX_LAST_DATA;
  endsequence

  sequence stop_begins;
    $rose(ti_reg) && !$past(wr_ctrl);
  endsequence

  chk_unused_reads_one: assert property (
    ctrl_read |=> SFR_RDATA[UNUSED_BIT])
    else $error("Unused control bit did not read as one.");

  chk_data_read_route: assert property (
    CE && rd_data |=> SFR_RDATA == $past(rx_buf_reg))
    else $error("Data read did not return the receive buffer.");

  chk_flag_clear_cpu: assert property (
    $fell(ti_reg) || $fell(ri_reg) |-> $past(wr_ctrl))
    else $error("A done flag cleared without a CPU write.");

  chk_irq_follows_flag: assert property (
    $rose(ri_reg) && INT_ENABLE |-> INT_REQ)
    else $error("Receive flag set without an interrupt request.");

  chk_rx_accept_gate: assert property (
    $rose(ri_reg) && !$past(wr_ctrl) |->
      $past(rx_last) && (!$past(filter_reg) || $past(rx_bit9)))
    else $error("Receive flag set without a valid acceptance.");

  chk_overrun_keeps_byte: assert property (
    CE && ri_reg && !wr_ctrl |=> $stable(rx_buf_reg))
    else $error("Receive buffer changed while the flag was set.");

  chk_idle_line_high: assert property (
    !tx_busy_reg |-> SERIAL_OUT)
    else $error("Transmit line not high while idle.");

  chk_ti_at_stop: assert property (
    stop_begins |-> tx_idx_reg == last_idx && SERIAL_OUT)
    else $error("Transmit flag set away from the stop bit start.");

  chk_ninth_bit_sent: assert property (
    ninth_slot |=> SERIAL_OUT == tx_ninth_reg)
    else $error("Ninth bit on the line differs from the loaded value.");

  chk_rx_timer_reload: assert property (
    CE && start_edge |=> rx_cnt_reg == $past(BAUD_RELOAD))
    else $error("Receive timer was not reloaded on a start edge.");

endmodule

`default_nettype wire

// file: src/_unused_placeholder_removed.sv
// Intentionally empty companion; no design content.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: dv/remote_uart.sv
// Remote serial node that sends frames to the port and captures its output.
`timescale 1ns/100ps
`default_nettype none

module remote_uart #(
  parameter int BIT = 32
) (
  input  wire logic clk,
  input  wire logic tx_line,
  input  wire logic nine_bit,
  output logic      rx_line
);
  logic [10:0] last_frame;
  int          frames;

  initial begin
    rx_line = 1'b1;
    frames = 0;
    last_frame = '0;
  end

  // Sends n bits LSB first, then lets the line return to its idle high.
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line = f[i];
      repeat (BIT) @(posedge clk);
      #1;
    end
    rx_line = 1'b1;
  endtask

  // Samples each bit of an outgoing frame in the middle of its cell.
  always begin : capture
    logic [10:0] s;
    @(negedge tx_line);
    s = '1;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < (nine_bit ? 11 : 10); i++) begin
      if (i != 0) repeat (BIT) @(posedge clk);
      #1;
      s[i] = tx_line;
    end
    last_frame = s;
    frames++;
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking testbench for the asynchronous serial port.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import serial_port_pkg::*;
  localparam logic [7:0] RELOAD = 8'hf0;
  localparam int         BIT = 2 * (256 - RELOAD);
  logic       clock, rst, wr, rd_s, int_en, ser_in, ser_out, irq, txr, nine;
  logic [7:0] addr, wdata, rdata, rd_val;
  int         errors, check_count, n0;

  serial_port uut (.CLOCK(clock), .RST(rst), .CE(1'b1), .SFR_ADDR(addr),
    .SFR_WR(wr), .SFR_RD(rd_s), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
    .TIMER_RUN(1'b1), .TIMER_TICK(1'b1), .BAUD_RELOAD(RELOAD),
    .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .INT_ENABLE(int_en),
    .INT_REQ(irq), .TX_READY(txr));
  remote_uart #(.BIT(BIT)) peer (.clk(clock), .tx_line(ser_out),
    .nine_bit(nine), .rx_line(ser_in));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clock);
    #1;
    wr = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    addr = a;
    rd_s = 1'b1;
    @(posedge clock);
    #1;
    rd_s = 1'b0;
    rd_val = rdata;
    @(posedge clock);
    #1;
  endtask

  task automatic wait_ctrl(input logic [7:0] mask);
    for (int i = 0; i < 2000; i++) begin
      rd_reg(CTRL_ADDR);
      if ((rd_val & mask) != 8'h00) break;
    end
    compare((rd_val & mask) != 8'h00, 1'b1);
  endtask

  task automatic wait_frames(input int n);
    for (int i = 0; i < 40 * 11 * BIT; i++) begin
      if (peer.frames >= n) break;
      @(posedge clock);
      #1;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_reg(CTRL_ADDR);
    compare(rd_val, 8'h40);
    rd_reg(DATA_ADDR);
    compare(rd_val, 8'h00);
    rd_reg(8'h97);
    compare(rd_val, UNMAPPED_READ);
    wr_reg(CTRL_ADDR, 8'h00);
    rd_reg(CTRL_ADDR);
    compare(rd_val, 8'h40);
    compare(ser_out, 1'b1);
  endtask

  task automatic t_tx8;
    nine = 1'b0;
    n0 = peer.frames;
    wr_reg(CTRL_ADDR, 8'h00);
    wr_reg(DATA_ADDR, 8'ha5);
    wait_ctrl(8'h02);
    compare(peer.frames, n0);
    compare(ser_out, 1'b1);
    wait_frames(n0 + 1);
    compare(peer.last_frame, {2'b11, 8'ha5, 1'b0});
    int_en = 1'b1;
    @(posedge clock);
    #1;
    compare(irq, 1'b1);
    int_en = 1'b0;
    @(posedge clock);
    #1;
    compare(irq, 1'b0);
    repeat (10 * BIT) @(posedge clock);
    #1;
    rd_reg(CTRL_ADDR);
    compare(rd_val, 8'h42);
    wr_reg(CTRL_ADDR, 8'h08);
    rd_reg(CTRL_ADDR);
    compare(rd_val, 8'h48);
  endtask

  task automatic t_tx9;
    nine = 1'b1;
    for (int b = 0; b < 2; b++) begin
      n0 = peer.frames;
      wr_reg(CTRL_ADDR, 8'h80 | (b != 0 ? 8'h08 : 8'h00));
      wr_reg(DATA_ADDR, 8'h3c);
      wait_ctrl(8'h02);
      wait_frames(n0 + 1);
      compare(peer.last_frame, {1'b1, b[0], 8'h3c, 1'b0});
    end
    wr_reg(CTRL_ADDR, 8'h00);
  endtask

  task automatic rx_case(input logic [7:0] c, input logic [10:0] f,
                         input int n, input logic [7:0] ec,
                         input logic [7:0] ed);
    wr_reg(CTRL_ADDR, c);
    peer.send(f, n);
    rd_reg(CTRL_ADDR);
    compare(rd_val, ec);
    rd_reg(DATA_ADDR);
    compare(rd_val, ed);
  endtask

  task automatic t_rx;
    nine = 1'b0;
    rx_case(8'h00, {2'b11, 8'h11, 1'b0}, 10, 8'h40, 8'h00);
    rx_case(8'h30, {2'b10, 8'h22, 1'b0}, 10, 8'h70, 8'h00);
    rx_case(8'h10, {2'b11, 8'h3c, 1'b0}, 10, 8'h55, 8'h3c);
    rx_case(8'h11, {2'b11, 8'h99, 1'b0}, 10, 8'h51, 8'h3c);
    rx_case(8'hb0, {2'b10, 8'h5a, 1'b0}, 11, 8'hf0, 8'h3c);
    rx_case(8'hb0, {2'b01, 8'h5a, 1'b0}, 11, 8'hf5, 8'h5a);
    rx_case(8'h90, {2'b10, 8'hc3, 1'b0}, 11, 8'hd1, 8'hc3);
  endtask

  task automatic t_fifo;
    int cnt;
    nine = 1'b0;
    cnt = 0;
    n0 = peer.frames;
    wr_reg(CTRL_ADDR, 8'h00);
    for (int i = 0; i < 20; i++) begin
      if (txr === 1'b1) begin
        wr_reg(DATA_ADDR, 8'(cnt));
        cnt++;
      end
    end
    compare(txr, 1'b0);
    compare(cnt >= FIFO_DEPTH && cnt <= FIFO_DEPTH + 1, 1'b1);
    wait_frames(n0 + cnt);
    compare(peer.frames - n0, cnt);
    compare(peer.last_frame, {2'b11, 8'(cnt - 1), 1'b0});
    compare(txr, 1'b1);
  endtask

  task automatic complete_run;
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    check_count = 0;
    rst = 1'b1;
    wr = 1'b0;
    rd_s = 1'b0;
    int_en = 1'b0;
    nine = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_tx8();
    t_tx9();
    t_rx();
    t_fifo();
    complete_run();
  end
endmodule
`default_nettype wire
